// *** pfc_pwm_pkg.sv ***
`default_nettype none
package pfc_pwm_pkg;
  // ********************************************************
  // register byte addresses
  // ********************************************************
  localparam logic [7:0] timer1_ctrl_a_addr  = 8'h80;
  localparam logic [7:0] timer1_ctrl_b_addr  = 8'h84;
  localparam logic [7:0] capture_top_addr    = 8'h88;
  localparam logic [7:0] compare_a_addr      = 8'h8c;
  localparam logic [7:0] timer3_ctrl_a_addr  = 8'h90;
  localparam logic [7:0] timer4_ctrl_a_addr  = 8'ha0;
  localparam logic [7:0] compare_b_addr      = 8'hb0;
  localparam logic [7:0] compare_c_addr      = 8'hb4;
  localparam logic [7:0] flags_addr          = 8'hb8;
  localparam logic [7:0] count_addr          = 8'hbc;
  localparam logic [7:0] pin_ctrl_addr       = 8'hc0;
  // ********************************************************
  // field positions, codes and reset values
  // ********************************************************
  localparam int         mode_hi_lsb         = 3;
  localparam int         clock_sel_lsb       = 0;
  localparam int         flag_overflow       = 0;
  localparam int         flag_capture        = 1;
  localparam int         flag_match_lsb      = 2;
  localparam int         port_value_lsb      = 3;
  localparam logic [3:0] mode_pfc_capture    = 4'h8;
  localparam logic [3:0] mode_pfc_compare_a  = 4'h9;
  localparam logic [3:0] mode_pc_compare_a   = 4'hb;
  localparam logic [1:0] action_off          = 2'h0;
  localparam logic [1:0] action_toggle       = 2'h1;
  localparam logic [1:0] action_noninv       = 2'h2;
  localparam logic [1:0] action_inv          = 2'h3;
  localparam logic [7:0] ctrl_reset          = 8'h00;
  localparam logic [15:0] value_reset        = 16'h0000;
  localparam logic [15:0] bottom_value       = 16'h0000;
  localparam logic [1:0] resp_okay           = 2'h0;
  localparam logic [1:0] resp_slverr         = 2'h2;

  // ********************************************************
  // state carrier
  // ********************************************************
  typedef struct packed {
    logic [7:0]       ctrl_a1;
    logic [7:0]       ctrl_a3;
    logic [7:0]       ctrl_a4;
    logic [7:0]       ctrl_b;
    logic [15:0]      cap_top;
    logic [2:0][15:0] buf_cmp;
    logic [2:0][15:0] act_cmp;
    logic [4:0]       flags;
    logic [2:0]       dir_en;
    logic [2:0]       port_val;
    logic [9:0]       presc;
    logic [15:0]      count;
    logic             down;
    logic [2:0]       wave;
    logic [2:0]       pin_out;
    logic [2:0]       pin_oe_n;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
  } pwm_state_type;
endpackage : pfc_pwm_pkg
`default_nettype wire

// *** pfc_pwm.sv ***
// Decided for this implementation: the AXI4-Lite register port.
`default_nettype none
// Functional notes
// R1 - modes 8 and 9 run phase-frequency correct
// R2 - count up to TOP, down to zero
// R3 - TOP from capture (8) or compare A (9)
// R4 - TOP value held for one tick
// R5 - software keeps TOP at least 0x0003
// R6 - clear on up match, set on down
// R7 - action two non-inverted, three inverted
// R8 - compare buffers load only at BOTTOM
// R9 - overflow flag set with buffer load
// R10 - TOP sets match A or capture flag
// R11 - equal count sets channel match flag
// R12 - software keeps TOP above all compares
// R13 - compare above TOP never matches
// R14 - pin driven only when direction is output
// R15 - BOTTOM compare low, TOP compare high
// R16 - mode 9 action one toggles A
// R17 - tick is clock divided by prescaler
// R18 - tick qualifies counting, flags and loads
// R19 - control A fields and zero reset
// R20 - action zero leaves normal port control
// R21 - mode high bits live in control B
// R22 - action one elsewhere leaves outputs disconnected; code also keeps A connected to its waveform in mode 11
// R23 - capture TOP takes effect unbuffered
module pfc_pwm
  import pfc_pwm_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // port pins of channels a, b, c
  output var  logic [2:0]  pin_out,
  output var  logic [2:0]  pin_oe_n
);
  pwm_state_type state;
  pwm_state_type next_state;
  logic [3:0]    mode;
  logic          pfc_mode;
  logic [15:0]   top;
  logic          tick;
  logic [9:0]    presc_last;
  logic [2:0]    sel_ok;
  logic [2:0]    connected;
  logic [2:0]    match;
  logic [2:0]    eff_down_ch;
  logic          at_top;
  logic          at_bottom;
  logic          eff_down;
  logic          wr_fire;
  logic          wr_hit;
  logic          rd_hit;
  logic [31:0]   rd_word;
  logic [4:0]    flag_set;
  logic [4:0]    flag_clr;

  // ********************************************************
  // prescaler and mode decode
  // ********************************************************
  always_comb begin
    case (state.ctrl_b[clock_sel_lsb +: 3]) // R17
      3'h1:    presc_last = 10'h000;
      3'h2:    presc_last = 10'h007;
      3'h3:    presc_last = 10'h03f;
      3'h4:    presc_last = 10'h0ff;
      3'h5:    presc_last = 10'h3ff;
      default: presc_last = 10'h000;
    endcase
  end

  assign sel_ok    = {1'b0, state.ctrl_b[clock_sel_lsb +: 3]} inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5} ? 3'h7 : 3'h0;
  assign tick      = sel_ok[0] && (state.presc == presc_last); // R17 R18
  assign mode      = {state.ctrl_b[mode_hi_lsb +: 2], state.ctrl_a1[1:0]}; // R21
  assign pfc_mode  = (mode == mode_pfc_capture) || (mode == mode_pfc_compare_a); // R1
  assign top       = (mode == mode_pfc_capture) ? state.cap_top : state.act_cmp[0]; // R3 R23
  assign at_top    = (state.count == top);
  assign at_bottom = (state.count == bottom_value);
  // at the turning points the slope is taken as the one being entered
  assign eff_down  = at_bottom ? 1'b0 : (at_top ? 1'b1 : state.down); // R15

  // ********************************************************
  // per channel compare and pin selection
  // ********************************************************
  for (genvar i = 0; i < 3; i++) begin : g_chan
    logic [1:0] sel;
    assign sel            = state.ctrl_a1[7 - 2 * i -: 2]; // R19
    assign match[i]       = (state.count == state.act_cmp[i]) && (state.act_cmp[i] <= top); // R11 R13
    assign eff_down_ch[i] = eff_down;
    if (i == 0) begin : g_a
      assign connected[i] = (sel >= action_noninv) ||
                            ((sel == action_toggle) &&
                             ((mode == mode_pfc_compare_a) || (mode == mode_pc_compare_a))); // R16 R22
    end else begin : g_bc
      assign connected[i] = (sel >= action_noninv); // R20 R22
    end
  end

  // ********************************************************
  // register bus decode
  // ********************************************************
  assign wr_fire = state.aw_got && state.w_got && !state.bvalid;
  assign wr_hit  = state.aw_addr inside {timer1_ctrl_a_addr, timer1_ctrl_b_addr, capture_top_addr,
                                         compare_a_addr, timer3_ctrl_a_addr, timer4_ctrl_a_addr,
                                         compare_b_addr, compare_c_addr, flags_addr, count_addr,
                                         pin_ctrl_addr};

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (araddr)
      timer1_ctrl_a_addr: rd_word[7:0]  = state.ctrl_a1;
      timer3_ctrl_a_addr: rd_word[7:0]  = state.ctrl_a3;
      timer4_ctrl_a_addr: rd_word[7:0]  = state.ctrl_a4;
      timer1_ctrl_b_addr: rd_word[7:0]  = state.ctrl_b;
      capture_top_addr:   rd_word[15:0] = state.cap_top;
      compare_a_addr:     rd_word[15:0] = state.buf_cmp[0];
      compare_b_addr:     rd_word[15:0] = state.buf_cmp[1];
      compare_c_addr:     rd_word[15:0] = state.buf_cmp[2];
      flags_addr:         rd_word[4:0]  = state.flags;
      count_addr:         rd_word[15:0] = state.count;
      pin_ctrl_addr:      rd_word[5:0]  = {state.port_val, state.dir_en};
      default:            rd_hit        = 1'b0;
    endcase
  end

  // byte-lane merge of a write into a register of up to 16 bits
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] res;
    res = old;
    if (s[0]) begin
      res[7:0] = d[7:0];
    end
    if (s[1]) begin
      res[15:8] = d[15:8];
    end
    return res;
  endfunction : merge16

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    next_state = state;
    flag_set   = 5'h00;
    flag_clr   = 5'h00;

    // write channels
    if (awvalid && state.awready) begin
      next_state.aw_got  = 1'b1;
      next_state.aw_addr = awaddr;
    end
    if (wvalid && state.wready) begin
      next_state.w_got  = 1'b1;
      next_state.w_data = wdata;
      next_state.w_strb = wstrb;
    end
    if (wr_fire) begin
      next_state.aw_got = 1'b0;
      next_state.w_got  = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp  = wr_hit ? resp_okay : resp_slverr;
      if (state.w_strb[0]) begin
        case (state.aw_addr)
          timer1_ctrl_a_addr: next_state.ctrl_a1 = state.w_data[7:0]; // R19
          timer3_ctrl_a_addr: next_state.ctrl_a3 = state.w_data[7:0]; // R19
          timer4_ctrl_a_addr: next_state.ctrl_a4 = state.w_data[7:0]; // R19
          timer1_ctrl_b_addr: next_state.ctrl_b  = {3'h0, state.w_data[4:0]};
          flags_addr:         flag_clr           = state.w_data[4:0];
          pin_ctrl_addr:      next_state.dir_en  = state.w_data[2:0];
          default:            ;
        endcase
        if (state.aw_addr == pin_ctrl_addr) begin
          next_state.port_val = state.w_data[port_value_lsb +: 3];
        end
      end
      case (state.aw_addr)
        capture_top_addr: next_state.cap_top    = merge16(state.cap_top, state.w_data, state.w_strb); // R23
        compare_a_addr:   next_state.buf_cmp[0] = merge16(state.buf_cmp[0], state.w_data, state.w_strb); // R8
        compare_b_addr:   next_state.buf_cmp[1] = merge16(state.buf_cmp[1], state.w_data, state.w_strb); // R8
        compare_c_addr:   next_state.buf_cmp[2] = merge16(state.buf_cmp[2], state.w_data, state.w_strb); // R8
        default:          ;
      endcase
    end
    if (state.bvalid && bready) begin
      next_state.bvalid = 1'b0;
    end
    next_state.awready = !next_state.aw_got && !next_state.bvalid;
    next_state.wready  = !next_state.w_got && !next_state.bvalid;

    // read channel
    if (arvalid && state.arready) begin
      next_state.arready = 1'b0;
      next_state.rvalid  = 1'b1;
      next_state.rdata   = rd_word;
      next_state.rresp   = rd_hit ? resp_okay : resp_slverr;
    end else if (state.rvalid && rready) begin
      next_state.rvalid  = 1'b0;
      next_state.arready = 1'b1;
    end

    // prescaler
    if (!sel_ok[0] || tick) begin
      next_state.presc = 10'h000;
    end else begin
      next_state.presc = state.presc + 10'h001;
    end

    // dual-slope counter
    if (tick && pfc_mode) begin // R18
      if (at_bottom) begin
        next_state.act_cmp = state.buf_cmp; // R8
        flag_set[flag_overflow] = 1'b1; // R9
      end
      if (at_top) begin
        if (mode == mode_pfc_capture) begin
          flag_set[flag_capture] = 1'b1; // R10
        end else begin
          flag_set[flag_match_lsb] = 1'b1; // R10
        end
      end
      // bottom wins: TOP may still read zero before the first buffer load
      if (at_bottom) begin
        next_state.count = state.count + 16'h0001; // R2
        next_state.down  = 1'b0;
      end else if (at_top) begin
        next_state.count = state.count - 16'h0001; // R4
        next_state.down  = 1'b1; // R3
      end else if (state.down) begin
        next_state.count = state.count - 16'h0001; // R2
      end else begin
        next_state.count = state.count + 16'h0001; // R2
      end
      for (int i = 0; i < 3; i++) begin
        if (match[i]) begin
          flag_set[flag_match_lsb + i] = 1'b1; // R11
          case (state.ctrl_a1[7 - 2 * i -: 2])
            action_noninv: next_state.wave[i] = eff_down_ch[i]; // R6 R7 R15
            action_inv:    next_state.wave[i] = !eff_down_ch[i]; // R6 R7 R15
            action_toggle: next_state.wave[i] = connected[i] ? !state.wave[i] : state.wave[i]; // R16
            default:       ;
          endcase
        end
      end
    end
    // a set in the clearing cycle wins
    next_state.flags = (state.flags & ~flag_clr) | flag_set;

    // port pins
    for (int i = 0; i < 3; i++) begin
      next_state.pin_out[i]  = connected[i] ? next_state.wave[i] : next_state.port_val[i]; // R20
      next_state.pin_oe_n[i] = !next_state.dir_en[i]; // R14
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state         <= '0;
      state.awready <= 1'b1;
      state.wready  <= 1'b1;
      state.arready <= 1'b1;
      state.pin_oe_n <= 3'h7;
    end else begin
      state <= next_state;
    end
  end

  assign awready  = state.awready;
  assign wready   = state.wready;
  assign bvalid   = state.bvalid;
  assign bresp    = state.bresp;
  assign arready  = state.arready;
  assign rvalid   = state.rvalid;
  assign rdata    = state.rdata;
  assign rresp    = state.rresp;
  assign pin_out  = state.pin_out;
  assign pin_oe_n = state.pin_oe_n;

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_mode_idle_hold: assert property (!pfc_mode && !wr_fire |=> $stable(state.count)) // R1
    else $error("counter moved outside the dual-slope modes");
  a_up_step_one: assert property (tick && pfc_mode && !state.down && !at_top |=>
                                  state.count == $past(state.count) + 16'h0001) // R2
    else $error("upward step was not one");
  a_top_turn_down: assert property (tick && pfc_mode && !state.down && at_top && !at_bottom |=>
                                    state.down && state.count == $past(top) - 16'h0001) // R3
    else $error("counter did not turn at top");
  a_top_one_tick: assert property (tick && pfc_mode && at_top && top > 16'h0001 && !wr_fire |=> !at_top) // R4
    else $error("top held for more than one tick");
  a_bottom_buffer_load: assert property (tick && pfc_mode && at_bottom && !wr_fire |=>
                                         state.act_cmp == $past(state.buf_cmp)) // R8
    else $error("compare buffers not loaded at bottom");
  a_mid_no_load: assert property (!(tick && pfc_mode && at_bottom) |=> $stable(state.act_cmp)) // R8
    else $error("active compare changed away from bottom");
  a_overflow_at_bottom: assert property (tick && pfc_mode && at_bottom |=> state.flags[flag_overflow]) // R9
    else $error("overflow flag missing at bottom");
  a_capture_at_top: assert property (tick && mode == mode_pfc_capture && at_top |=> state.flags[flag_capture]) // R10
    else $error("capture flag missing at top");
  a_match_b_flag: assert property (tick && pfc_mode && match[1] |=> state.flags[flag_match_lsb + 1]) // R11
    else $error("match flag b missing");
  a_above_top_quiet: assert property (state.act_cmp[2] > top |-> !match[2]) // R13
    else $error("match above top");
  a_noninv_up_clear: assert property (tick && pfc_mode && match[1] && !eff_down &&
                                      state.ctrl_a1[5:4] == action_noninv |=> !state.wave[1]) // R6
    else $error("non-inverted channel b not cleared on up match");
  a_inv_down_clear: assert property (tick && pfc_mode && match[2] && eff_down &&
                                     state.ctrl_a1[3:2] == action_inv |=> !state.wave[2]) // R7
    else $error("inverted channel c not cleared on down match");
  a_pin_dir_gate: assert property (!state.dir_en[0] |-> state.pin_oe_n[0]) // R14
    else $error("pin a driven while direction is input");
  a_toggle_a_wave: assert property (tick && mode == mode_pfc_compare_a && match[0] &&
                                    state.ctrl_a1[7:6] == action_toggle |=> state.wave[0] != $past(state.wave[0])) // R16
    else $error("channel a did not toggle");
  a_prescale_tick: assert property (state.ctrl_b[2:0] == 3'h2 && tick |=> !tick [*7]) // R17
    else $error("divide by eight tick too often");

  // slope actions, flags, tick gating, pin routing and register writes
  a_noninv_down_set: assert property (tick && pfc_mode && match[1] && eff_down &&
                                      state.ctrl_a1[5:4] == action_noninv |=> state.wave[1]) // R6
    else $error("non-inverted channel b not set on down match");
  a_inv_up_set: assert property (tick && pfc_mode && match[2] && !eff_down &&
                                 state.ctrl_a1[3:2] == action_inv |=> state.wave[2]) // R7
    else $error("inverted channel c not set on up match");
  a_match_a_flag: assert property (tick && pfc_mode && match[0] |=> state.flags[flag_match_lsb]) // R11
    else $error("match flag a missing");
  a_match_c_flag: assert property (tick && pfc_mode && match[2] |=> state.flags[flag_match_lsb + 2]) // R11
    else $error("match flag c missing");
  a_tick_gates_count: assert property (!tick |=> $stable(state.count)) // R18
    else $error("counter moved without a tick");
  a_stopped_no_tick: assert property (state.ctrl_b[2:0] == 3'h0 |-> !tick) // R17
    else $error("tick while prescaler stopped");
  a_pin_drive_out: assert property (state.dir_en[2] |-> !state.pin_oe_n[2]) // R14
    else $error("pin c not driven while direction is output");
  a_port_when_off: assert property (!connected[1] |=> state.pin_out[1] == state.port_val[1]) // R20
    else $error("disconnected channel b pin not under port control");
  a_toggle_b_off: assert property (state.ctrl_a1[5:4] == action_toggle |=> state.pin_out[1] == state.port_val[1]) // R22
    else $error("toggle action drove channel b");
  a_capture_top_direct: assert property (wr_fire && state.aw_addr == capture_top_addr && state.w_strb[1:0] == 2'h3 |=>
                                         state.cap_top == $past(state.w_data[15:0])) // R23
    else $error("capture top not taken at once");
  a_ctrl3_store: assert property (wr_fire && state.aw_addr == timer3_ctrl_a_addr && state.w_strb[0] |=>
                                  state.ctrl_a3 == $past(state.w_data[7:0])) // R19
    else $error("timer3 control a not stored");

  c_reach_top:    cover property (tick && pfc_mode && at_top);
  c_reach_bottom: cover property (tick && pfc_mode && at_bottom && state.down);
  c_write_done:   cover property (state.bvalid && bready);
  c_capture_top:  cover property (tick && mode == mode_pfc_capture && at_top);
  c_toggle_a:     cover property (tick && mode == mode_pfc_compare_a && match[0] && connected[0]);
endmodule : pfc_pwm
`default_nettype wire

// *** pfc_pwm_unused.sv ***
`default_nettype none
`default_nettype wire

// *** pfc_pwm_load.sv ***
`default_nettype none
module pfc_pwm_load (
  // pins of the timer
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe_n,
  // level seen by the load
  output var  logic [2:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // pull-down load: a released pin reads low
  // ****
  assign pin_level = ~pin_oe_n & pin_out;
endmodule : pfc_pwm_load
`default_nettype wire

// *** dual_slope_freq_correct_pwm_tb.sv ***
`default_nettype none
module dual_slope_freq_correct_pwm_tb
  import pfc_pwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // bench signals
  // ****
  logic        core_clk = 1'b0, rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, last_resp;
  logic [31:0] rdata, rd_data;
  logic [2:0]  pin_out, pin_oe_n, pin_level;
  int          fail_count = 0, checked = 0;
  int          divs[5] = '{1, 8, 64, 256, 1024};

  always #5 core_clk = ~core_clk;

  pfc_pwm DUT (
    .core_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pin_out, .pin_oe_n
  );
  pfc_pwm_load load (.pin_out, .pin_oe_n, .pin_level);

  // ****
  // helpers
  // ****
  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic do_reset;
    rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
  endtask : do_reset

  // one write or one read; waits for the answer under a bounded count
  task automatic bus(input bit wr_op, input logic [7:0] a, input logic [31:0] d);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    @(posedge core_clk);
    if (wr_op) begin
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hf;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
    end else begin
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
    end
    while (!done) begin
      @(posedge core_clk);
      n++;
      if (n > 500) begin
        fail_count++;
        $display("[FAIL] %0t bus answer missing", $time);
        tally_and_finish();
      end
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (arready === 1'b1) arvalid <= 1'b0;
      if (bvalid === 1'b1 && bready) begin
        last_resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
      if (rvalid === 1'b1 && rready) begin
        rd_data = rdata;
        last_resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : bus

  // high cycles of a channel over two full periods
  function automatic int exp_high(int mode, int act, int ch, int cmp, int top, int n);
    case (act)
      1: return (ch == 0 && mode == 9) ? 2 * top * n : 0;
      2: return (cmp > top) ? 0 : 4 * cmp * n;
      3: return 4 * (top - cmp) * n;
      default: return 0;
    endcase
  endfunction : exp_high

  task automatic run(input logic [3:0] mode, input int code, top, ca, cb, cc, input logic [5:0] acts);
    int n;
    int w;
    int cmp[3];
    int hi[3];
    logic [4:0] ef;
    n = divs[code-1];
    w = 4 * top * n;
    cmp = '{ca, cb, cc};
    hi = '{0, 0, 0};
    ef = {cc <= top, cb <= top, ca <= top, mode == 4'h8, 1'b1};
    do_reset();
    bus(1'b1, compare_a_addr, 32'(ca));
    bus(1'b1, capture_top_addr, 32'(top));
    bus(1'b1, compare_b_addr, 32'(cb));
    bus(1'b1, compare_c_addr, 32'(cc));
    bus(1'b1, pin_ctrl_addr, 32'h7);
    bus(1'b1, timer1_ctrl_a_addr, {24'h0, acts, mode[1:0]});
    bus(1'b1, timer1_ctrl_b_addr, {27'h0, mode[3:2], 3'(code)});
    bus(1'b0, timer1_ctrl_b_addr, 32'h0);
    chk(rd_data, {27'h0, mode[3:2], 3'(code)}, "ctrl b");
    repeat (w + 8) @(posedge core_clk);
    bus(1'b1, flags_addr, 32'h1f);
    repeat (w) begin
      @(negedge core_clk);
      for (int i = 0; i < 3; i++) hi[i] += int'(pin_level[i] === 1'b1);
    end
    for (int i = 0; i < 3; i++) begin
      chk(32'(hi[i]), 32'(exp_high(int'(mode), int'(acts[5-2*i -: 2]), i, cmp[i], top, n)), "high");
    end
    bus(1'b0, flags_addr, 32'h0);
    chk(rd_data, {27'h0, ef}, "flags");
  endtask : run

  // ****
  // main sequence
  // ****
  initial begin
    logic [7:0]  v;
    logic [7:0]  regs[3];
    logic [31:0] cnt;
    int          top;
    regs = '{timer1_ctrl_a_addr, timer3_ctrl_a_addr, timer4_ctrl_a_addr};
    void'($urandom(32'h2341e35c));
    do_reset();
    foreach (regs[i]) begin
      v = 8'($urandom);
      bus(1'b0, regs[i], 32'h0);
      chk(rd_data, {24'h0, ctrl_reset}, "ctrl reset");
      bus(1'b1, regs[i], {24'h0, v});
      bus(1'b0, regs[i], 32'h0);
      chk(rd_data, {24'h0, v}, "ctrl rw");
    end
    bus(1'b1, 8'hfc, 32'h5a);
    chk(32'(last_resp), 32'(resp_slverr), "wr unmapped");
    bus(1'b0, 8'hfc, 32'h0);
    chk({rd_data[29:0], last_resp}, {30'h0, resp_slverr}, "rd unmapped");
    bus(1'b1, timer1_ctrl_a_addr, 32'h0);
    bus(1'b1, pin_ctrl_addr, 32'h1d);
    repeat (3) @(negedge core_clk);
    chk({26'h0, pin_oe_n, pin_out}, 32'h13, "port pins");
    chk(32'(pin_level), 32'h1, "pin level");
    run(4'h9, 1, 5, 5, 2, 3, 6'h2b);
    run(4'h9, 1, 6, 6, 0, 7, 6'h1a);
    run(4'h8, 2, 4, 1, 4, 2, 6'h3d);
    run(4'h8, 1, 3, 0, 1, 2, 6'h1b);
    for (int c = 1; c <= 5; c++) begin
      top = (c < 4) ? 3 + int'($urandom % 4) : 3;
      run(4'h9, c, top, top, int'($urandom % (top + 1)), int'($urandom % (top + 1)), 6'h2b);
    end
    bus(1'b1, timer1_ctrl_b_addr, 32'h8);
    bus(1'b0, count_addr, 32'h0);
    cnt = rd_data;
    bus(1'b1, flags_addr, 32'h1f);
    repeat (50) @(posedge core_clk);
    bus(1'b0, count_addr, 32'h0);
    chk(rd_data, cnt, "count frozen");
    bus(1'b0, flags_addr, 32'h0);
    chk(rd_data, 32'h0, "flags quiet");
    tally_and_finish();
  end

  initial begin
    #1_000_000;
    fail_count++;
    $display("[FAIL] %0t run did not complete", $time);
    tally_and_finish();
  end
endmodule : dual_slope_freq_correct_pwm_tb
`default_nettype wire
